//--- gsb_top.sv
// General-purpose pin status bank: two status registers over sixteen pins
`timescale 1ns/1ps
`include "gsb_consts.svh"
module gsb_top #(
   parameter int NPINS = 16,
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register access port
   input wire gsb_pkg::gsb_addr_t reg_addr,
   input wire logic reg_wr,
   input wire gsb_pkg::gsb_byte_t reg_wdata,
   input wire logic reg_rd,
   output gsb_pkg::gsb_byte_t reg_rdata,
   output logic reg_rd_valid,
   // Pin configuration registers, held elsewhere
   input wire gsb_pkg::gsb_byte_t pin_cfg_1,
   input wire gsb_pkg::gsb_byte_t pin_cfg_2,
   input wire gsb_pkg::gsb_byte_t pin_cfg_3,
   input wire gsb_pkg::gsb_byte_t pin_cfg_4,
   input wire gsb_pkg::gsb_pins_t pin_dir_out,
   // General-purpose pins, bit n is general_pin_n
   input wire gsb_pkg::gsb_pins_t general_pin_in,
   output gsb_pkg::gsb_pins_t general_pin_out,
   output gsb_pkg::gsb_pins_t general_pin_oe,
   // Status view
   output gsb_pkg::gsb_pins_t pin_status
);
   import gsb_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (NPINS != `GSB_NPINS) begin : g_chk_pins
      $error("gsb_top: pin count must match the two status registers");
   end
   if (SYNC_STAGES != `GSB_SYNC_STAGES) begin : g_chk_sync
      $error("gsb_top: only a two-stage synchroniser is provided");
   end
   if (`GSB_NCFG * `GSB_PINS_PER_CFG != NPINS) begin : g_chk_cfg
      $error("gsb_top: config registers must cover every pin");
   end
   if (`GSB_POL_STRIDE * (`GSB_PINS_PER_CFG - 1) + `GSB_POL_OFFSET >= `GSB_REG_W) begin : g_fit
      $error("gsb_top: polarity bits must fit in one config byte");
   end
   if (`GSB_ADDR_STATUS_LOW == `GSB_ADDR_STATUS_HIGH) begin : g_chk_addr
      $error("gsb_top: the two status registers need distinct addresses");
   end

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------
   // Which status register an address selects
   function automatic gsb_sel_t reg_sel(input gsb_addr_t addr);
      gsb_sel_t sel;
      sel = GSB_SEL_NONE;
      case (addr)
         `GSB_ADDR_STATUS_LOW: begin
            sel = GSB_SEL_LOW;
         end
         `GSB_ADDR_STATUS_HIGH: begin
            sel = GSB_SEL_HIGH;
         end
         default: begin
            sel = GSB_SEL_NONE;
         end
      endcase
      return sel;
   endfunction

   // Polarity bit of the pin at slot k within its config register
   function automatic logic pol_bit(input gsb_byte_t cfg, input int k);
      int idx;
      idx = `GSB_POL_STRIDE * k + `GSB_POL_OFFSET;
      return cfg[idx];
   endfunction

   // Maps between pin level and assertion under a polarity
   function automatic logic apply_pol(input logic act_hi, input logic val);
      logic lvl;
      lvl = act_hi ? val : ~val;
      return lvl;
   endfunction

   // Status byte that a read of the selected register returns
   function automatic gsb_byte_t read_byte(input gsb_sel_t sel, input gsb_pins_t bits);
      gsb_byte_t b;
      case (sel)
         GSB_SEL_LOW: begin
            b = bits[`GSB_REG_W-1:0];
         end
         GSB_SEL_HIGH: begin
            b = bits[NPINS-1:`GSB_REG_W];
         end
         default: begin
            b = `GSB_RDATA_UNMAPPED;
         end
      endcase
      return b;
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   gsb_state_t st_r;
   gsb_state_t st_nxt;

   gsb_pins_t pin_sync;
   gsb_pins_t act_high;
   gsb_pins_t pin_asserted;
   gsb_pins_t wr_hit;
   gsb_pins_t wr_bit;
   gsb_sel_t wr_sel;
   gsb_sel_t rd_sel;
   gsb_byte_t cfg_regs [`GSB_NCFG];

   assign cfg_regs[0] = pin_cfg_1;
   assign cfg_regs[1] = pin_cfg_2;
   assign cfg_regs[2] = pin_cfg_3;
   assign cfg_regs[3] = pin_cfg_4;
   assign wr_sel = reg_sel(reg_addr);
   assign rd_sel = wr_sel;

   // ------------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------------
   gsb_sync #(
      .W(NPINS)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .d(general_pin_in),
      .q(pin_sync)
   );

   // ------------------------------------------------------------------
   // Per-pin polarity and write qualification
   // ------------------------------------------------------------------
   for (genvar g = 0; g < NPINS; g++) begin : g_pin
      // Config register and slot holding this pin's polarity
      localparam int CFG = g / `GSB_PINS_PER_CFG;
      localparam int SLOT = g % `GSB_PINS_PER_CFG;
      localparam int HALF = g / `GSB_REG_W;
      localparam int BIT = g % `GSB_REG_W;

      if (CFG == 0) begin : g_c1
         assign act_high[g] = pol_bit(cfg_regs[CFG], SLOT);
      end else if (CFG == 1) begin : g_c2
         assign act_high[g] = pol_bit(cfg_regs[CFG], SLOT);
      end else if (CFG == 2) begin : g_c3
         assign act_high[g] = pol_bit(cfg_regs[CFG], SLOT);
      end else begin : g_c4
         assign act_high[g] = pol_bit(cfg_regs[CFG], SLOT);
      end

      // Asserted means high or low as polarity selects
      assign pin_asserted[g] = apply_pol(act_high[g], pin_sync[g]);

      // Writes land only on output pins of the addressed register
      if (HALF == 0) begin : g_lo
         assign wr_hit[g] = reg_wr && pin_dir_out[g] && (wr_sel == GSB_SEL_LOW);
      end else begin : g_hi
         assign wr_hit[g] = reg_wr && pin_dir_out[g] && (wr_sel == GSB_SEL_HIGH);
      end

      // Write data bit that lands on this pin
      assign wr_bit[g] = reg_wdata[BIT];
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;

      // Input pins track the pin; output pins keep their value until written
      for (int i = 0; i < NPINS; i++) begin
         if (!pin_dir_out[i]) begin
            st_nxt.status[i] = pin_asserted[i];
         end else if (wr_hit[i]) begin
            st_nxt.status[i] = wr_bit[i];
         end
      end

      // Output pins follow the status bit through polarity
      for (int i = 0; i < NPINS; i++) begin
         st_nxt.pin_out[i] = apply_pol(act_high[i], st_nxt.status[i]);
      end
      // Drive enable follows the direction one cycle later
      st_nxt.pin_oe = pin_dir_out;

      // Reads return the value held before this cycle's update
      if (reg_rd) begin
         st_nxt.rd_valid = 1'b1;
         st_nxt.rdata = read_byte(rd_sel, st_r.status);
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r.status <= {`GSB_STATUS_RESET, `GSB_STATUS_RESET};
         // Pins stay undriven until the first edge after release
         st_r.pin_out <= '0;
         st_r.pin_oe <= '0;
         st_r.rdata <= `GSB_RDATA_UNMAPPED;
         st_r.rd_valid <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reg_rdata = st_r.rdata;
   assign reg_rd_valid = st_r.rd_valid;
   assign general_pin_out = st_r.pin_out;
   assign general_pin_oe = st_r.pin_oe;
   assign pin_status = st_r.status;
endmodule

//--- gsb_consts.svh
// Constants for the general-purpose pin status bank
//
// Contract
// - Input pin: status bit reads 1 while pin sits at asserted level, else 0.
// - Output pin: writing 1 drives asserted level, writing 0 drives deasserted level.
// - Status bit writable only while its pin is an output; otherwise writes ignored.
// - Polarity of pins 0 to 3 from bits 1,3,5,7 of config register 1.
// - Polarity of pins 4 to 7 from bits 1,3,5,7 of config register 2.
// - Polarity of pins 8 to 11 from bits 1,3,5,7 of config register 3.
// - Polarity of pins 12 to 15 from bits 1,3,5,7 of config register 4.
// - Register 0x24 holds status of pins 0 to 7, zero at reset.
// - Register 0x25 holds status of pins 8 to 15, zero at reset.
`ifndef GSB_CONSTS_SVH
`define GSB_CONSTS_SVH

`define GSB_ADDR_W 8
`define GSB_REG_W 8
`define GSB_NPINS 16
`define GSB_NCFG 4
`define GSB_PINS_PER_CFG 4
`define GSB_ADDR_STATUS_LOW 8'h24
`define GSB_ADDR_STATUS_HIGH 8'h25
`define GSB_STATUS_RESET 8'h00
`define GSB_RDATA_UNMAPPED 8'h00
`define GSB_POL_STRIDE 2
`define GSB_POL_OFFSET 1
`define GSB_SYNC_STAGES 2

`endif

//--- gsb_pkg.sv
// Types shared by the general-purpose pin status bank
package gsb_pkg;
   `include "gsb_consts.svh"

   typedef logic [`GSB_REG_W-1:0] gsb_byte_t;
   typedef logic [`GSB_ADDR_W-1:0] gsb_addr_t;
   typedef logic [`GSB_NPINS-1:0] gsb_pins_t;

   typedef enum {
      GSB_SEL_NONE,
      GSB_SEL_LOW,
      GSB_SEL_HIGH
   } gsb_sel_t;

   typedef struct packed {
      gsb_pins_t status;
      gsb_pins_t pin_out;
      gsb_pins_t pin_oe;
      gsb_byte_t rdata;
      logic rd_valid;
   } gsb_state_t;
endpackage

//--- gsb_sync.sv
// Two-stage level synchroniser for the pin inputs
`timescale 1ns/1ps
module gsb_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } gsb_sync_state_t;

   gsb_sync_state_t st_r;
   gsb_sync_state_t st_nxt;

   if (W < 1) begin : g_chk
      $error("gsb_sync: width must be at least one");
   end

   // First stage feeds only the second stage
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = d;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.stable;
endmodule

//--- gsb_chk.sv
// Assertions on the pin status bank ports
`timescale 1ns/1ps
module gsb_chk (
   // Clock, reset, register port
   input wire logic clk,
   input wire logic rst,
   input wire gsb_pkg::gsb_addr_t reg_addr,
   input wire logic reg_wr,
   input wire gsb_pkg::gsb_byte_t reg_wdata,
   input wire logic reg_rd,
   input wire gsb_pkg::gsb_byte_t reg_rdata,
   input wire logic reg_rd_valid,
   // Config and pins
   input wire gsb_pkg::gsb_byte_t pin_cfg_1,
   input wire gsb_pkg::gsb_byte_t pin_cfg_2,
   input wire gsb_pkg::gsb_byte_t pin_cfg_3,
   input wire gsb_pkg::gsb_byte_t pin_cfg_4,
   input wire gsb_pkg::gsb_pins_t pin_dir_out,
   input wire gsb_pkg::gsb_pins_t general_pin_in,
   input wire gsb_pkg::gsb_pins_t general_pin_out,
   input wire gsb_pkg::gsb_pins_t general_pin_oe,
   input wire gsb_pkg::gsb_pins_t pin_status
);
   import gsb_pkg::*;
   logic [31:0] cc;
   gsb_pins_t pol;
   logic [2:0] up_r;
   logic wl, wh, rl, rh;
   assign cc = {pin_cfg_4, pin_cfg_3, pin_cfg_2, pin_cfg_1};
   assign wl = reg_wr && reg_addr == 8'h24;
   assign wh = reg_wr && reg_addr == 8'h25;
   assign rl = reg_rd && reg_addr == 8'h24;
   assign rh = reg_rd && reg_addr == 8'h25;
   // Pin n polarity sits at bit 2n+1 of the joined config
   always_comb for (int i = 0; i < 16; i++) pol[i] = cc[2*i+1];
   // Cycles since reset release, saturating
   always_ff @(posedge clk) begin
      if (rst) up_r <= 3'h0;
      else if (up_r != 3'h4) up_r <= up_r + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rd_valid_a: assert property (1 |=> reg_rd_valid == $past(reg_rd))
      else $error("read valid not one cycle after read");
   rd_low_a: assert property (rl |=> reg_rdata == $past(pin_status[7:0]))
      else $error("low status read wrong");
   rd_high_a: assert property (rh |=> reg_rdata == $past(pin_status[15:8]))
      else $error("high status read wrong");
   in_follow_a: assert property (up_r == 3'h4 |->
      ((pin_status ^ ~($past(general_pin_in, 3) ^ $past(pol))) & ~$past(pin_dir_out)) == '0)
      else $error("input status not following pin");
   out_drive_a: assert property (up_r != 3'h0 |->
      (general_pin_oe & (general_pin_out ^ pin_status ^ ~$past(pol))) == '0)
      else $error("pin drive not matching status");
   wr_low_a: assert property (wl |=>
      ((pin_status[7:0] ^ $past(reg_wdata)) & $past(pin_dir_out[7:0])) == '0)
      else $error("low write not taken");
   wr_high_a: assert property (wh |=>
      ((pin_status[15:8] ^ $past(reg_wdata)) & $past(pin_dir_out[15:8])) == '0)
      else $error("high write not taken");
   wr_hold_a: assert property (!wl && !wh |=>
      ((pin_status ^ $past(pin_status)) & $past(pin_dir_out)) == '0)
      else $error("output status moved without write");
   cover property (wh);
   cover property (up_r == 3'h4 && |general_pin_oe);
   cover property (rl && |pin_status[7:0]);
endmodule
bind gsb_top gsb_chk i_gsb_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
   .reg_rdata, .reg_rd_valid, .pin_cfg_1, .pin_cfg_2, .pin_cfg_3, .pin_cfg_4,
   .pin_dir_out, .general_pin_in, .general_pin_out, .general_pin_oe, .pin_status);

//--- gsb_pins.sv
// Outside logic levels on the general-purpose pins
`timescale 1ns/1ps
module gsb_pins (
   // Outside level and device drive
   input wire gsb_pkg::gsb_pins_t ext_lvl,
   input wire gsb_pkg::gsb_pins_t dev_out,
   input wire gsb_pkg::gsb_pins_t dev_oe,
   // Resolved wire
   output gsb_pkg::gsb_pins_t wire_lvl
);
   // Device wins where it drives
   assign wire_lvl = (dev_oe & dev_out) | (~dev_oe & ext_lvl);
endmodule

//--- testbench.sv
// Directed tests for the pin status bank
`timescale 1ns/1ps
module testbench;
   import gsb_pkg::*;
   logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, reg_rd_valid;
   gsb_addr_t reg_addr = 8'h00;
   gsb_byte_t reg_wdata = 8'h00, reg_rdata;
   gsb_byte_t c1 = 8'hAA, c2 = 8'hAA, c3 = 8'hAA, c4 = 8'hAA;
   gsb_pins_t dir = 16'h0000, ext = 16'h0000, lvl, p_out, p_oe, p_st, s;
   logic [31:0] pt [4] = '{32'hAAAAAAAA, 32'h80200802, 32'h02082080, 32'h00000000};
   int miscompares = 0, num_checks = 0, cyc = 0;
   gsb_top i_gsb_top (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .reg_rd_valid, .pin_cfg_1(c1), .pin_cfg_2(c2), .pin_cfg_3(c3), .pin_cfg_4(c4),
      .pin_dir_out(dir), .general_pin_in(lvl), .general_pin_out(p_out),
      .general_pin_oe(p_oe), .pin_status(p_st));
   gsb_pins i_gsb_pins (.ext_lvl(ext), .dev_out(p_out), .dev_oe(p_oe), .wire_lvl(lvl));
   initial forever #10 clk = ~clk;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tk(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(gsb_addr_t a, gsb_byte_t d);
      tk(1);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      tk(1);
      reg_wr = 1'h0;
   endtask
   task automatic rd(gsb_addr_t a, gsb_byte_t e);
      tk(1);
      reg_rd = 1'h1;
      reg_addr = a;
      tk(1);
      reg_rd = 1'h0;
      chk("valid", 16'h0001, reg_rd_valid);
      chk("rdata", e, reg_rdata);
   endtask
   // Expected input status: asserted when level matches polarity
   function automatic gsb_pins_t st(gsb_pins_t p);
      logic [31:0] cc;
      gsb_pins_t r;
      cc = {c4, c3, c2, c1};
      for (int i = 0; i < 16; i++) r[i] = ~(p[i] ^ cc[2*i+1]);
      return r;
   endfunction
   initial begin
      tk(10);
      rst = 1'h0;
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      ext = 16'hA5C3;
      foreach (pt[k]) begin
         {c4, c3, c2, c1} = pt[k];
         tk(4);
         s = st(ext);
         rd(8'h24, s[7:0]);
         rd(8'h25, s[15:8]);
         wr(8'h24, ~s[7:0]);
         rd(8'h24, s[7:0]);
      end
      {c4, c3, c2, c1} = 32'hAAAAAAAA;
      ext = 16'h0000;
      dir = 16'h0F0F;
      tk(4);
      wr(8'h24, 8'h5A);
      wr(8'h25, 8'h3C);
      rd(8'h24, 8'h0A);
      rd(8'h25, 8'h0C);
      chk("pins", 16'h0C0A, p_out & p_oe);
      chk("oe", 16'h0F0F, p_oe);
      chk("status", 16'h0C0A, p_st);
      {c4, c3, c2, c1} = 32'h00000000;
      tk(1);
      chk("pins", 16'h0305, p_out & p_oe);
      dir = 16'h0000;
      tk(4);
      wr(8'h26, 8'h00);
      rd(8'h26, 8'h00);
      rd(8'h24, 8'hFF);
      wrap_up();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         wrap_up();
      end
   end
endmodule
